// ### dv/scpi_link_assertions.sv
// scpi_link_assertions.sv: concurrent checks on the ddr2 ball-level link
// assumes: fed the link signals by name beside the interface; ck_t domain only
`timescale 1ns/100ps
`include "scpi_consts.svh"
module scpi_link_assertions #(
    parameter int AW = 14
) (
    input wire logic ck_t,
    input wire logic sys_rst_i,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [AW-1:0] addr,
    input wire logic c_dq_oe_n,
    input wire logic c_dqs_oe_n,
    input wire logic d_dq_oe_n,
    input wire logic d_dqs_oe_n,
    input wire logic d_dqsc_oe_n,
    input wire logic d_rdqs_oe_n,
    input wire logic dqs
);
    logic [3:0] cmd;
    logic live;
    logic acc_rd;
    logic cke_q;
    logic e10_q;
    logic [7:0] open_q;

    // a command counts only with cke registered high twice running
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign live = cke && cke_q;
    assign acc_rd = live && cmd == `SCPI_CMD_RD && open_q[ba];

    // shadow of the registered clock enable
    always_ff @(posedge ck_t or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
        end
    end

    // shadow of open rows, so reads to closed banks are told apart
    always_ff @(posedge ck_t or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            open_q <= 8'h00;
        end else if (live && cmd == `SCPI_CMD_ACT) begin
            open_q[ba] <= 1'b1;
        end else if (live && cmd == `SCPI_CMD_PRE) begin
            open_q <= addr[`SCPI_A10] ? 8'h00 : open_q & ~(8'h01 << ba);
        end else if (live && (cmd == `SCPI_CMD_RD || cmd == `SCPI_CMD_WR) && addr[`SCPI_A10]) begin
            open_q[ba] <= 1'b0;
        end
    end

    // strobe mode bit of the extended mode register
    always_ff @(posedge ck_t or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            e10_q <= 1'b0;
        end else if (live && cmd == `SCPI_CMD_MRS && ba == 3'h1) begin
            e10_q <= addr[`SCPI_E10];
        end
    end

    default clocking cb @(posedge ck_t); endclocking
    default disable iff (sys_rst_i);

    chk_rd_drives: assert property (acc_rd |=> !d_dq_oe_n && !d_dqs_oe_n && !dqs)
        else $error("accepted read not driven for one link period");
    chk_no_stray: assert property (!acc_rd |=> d_dq_oe_n)
        else $error("device drove data without an accepted read");
    chk_pd_silent: assert property (!cke |=> d_dq_oe_n && d_dqs_oe_n)
        else $error("device drove data with clock enable low");
    chk_strobe_mode: assert property (acc_rd |=> d_dqsc_oe_n == e10_q)
        else $error("complementary strobe use differs from mode");
    chk_rdqs_quiet: assert property (d_dq_oe_n |-> d_rdqs_oe_n)
        else $error("redundant strobe driven outside read data");
    chk_ctl_deselect: assert property ((cmd == `SCPI_CMD_WR || cmd == `SCPI_CMD_RD) |=> cs_n)
        else $error("no deselect period after a data command");
    chk_wr_data_out: assert property (cmd == `SCPI_CMD_WR |=> !c_dq_oe_n && !c_dqs_oe_n ##1 c_dq_oe_n)
        else $error("write data not driven for exactly the next period");
    chk_one_driver: assert property (!(d_dq_oe_n == 1'b0 && c_dq_oe_n == 1'b0))
        else $error("both ends drive the data bus");
endmodule // scpi_link_assertions

// ### dv/test_sdram_command_pin_interface.sv
// test_sdram_command_pin_interface.sv: controller and device ends face to face
// assumes: package, interface, both ends and the checker compiled first
`timescale 1ns/100ps
module test_sdram_command_pin_interface;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [2:0] req_cmd_i = 3'h0;
    logic [2:0] req_ba_i = 3'h0;
    logic [13:0] req_addr_i = 14'h0000;
    logic [31:0] req_wdata_i = 32'h0000_0000;
    logic [3:0] req_wmask_i = 4'h0;
    logic cke_i = 1'b0;
    logic odt_i = 1'b0;
    logic req_ready_o, rsp_valid_o, clk_on_o, self_ref_o, odt_on_o;
    logic [31:0] rsp_rdata_o;
    logic [2:0] pwr_state_o;
    logic [7:0] banks_open_o;
    logic [15:0] emr_o;
    int failures = 0;
    int n_compared = 0;

    // 50 MHz system clock; the link clock is divided from it inside the controller
    always #10 clk_sys_i = ~clk_sys_i;

    // widths come from the module defaults, so both ends and the checker always agree
    scpi_if lnk_if ();
    scpi_ctl scpi_ctl_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_cmd_i(req_cmd_i), .req_ba_i(req_ba_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_wmask_i(req_wmask_i), .cke_i(cke_i), .odt_i(odt_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .lnk(lnk_if));
    scpi_dev scpi_dev_inst (
        .lnk(lnk_if), .sys_rst_i(sys_rst_i), .clk_on_o(clk_on_o), .pwr_state_o(pwr_state_o),
        .self_ref_o(self_ref_o), .odt_on_o(odt_on_o), .banks_open_o(banks_open_o), .emr_o(emr_o));
    scpi_link_assertions scpi_link_assertions_inst (
        .ck_t(lnk_if.ck_t), .sys_rst_i(sys_rst_i), .cke(lnk_if.cke), .cs_n(lnk_if.cs_n),
        .ras_n(lnk_if.ras_n), .cas_n(lnk_if.cas_n), .we_n(lnk_if.we_n), .ba(lnk_if.ba), .addr(lnk_if.addr),
        .c_dq_oe_n(lnk_if.c_dq_oe_n), .c_dqs_oe_n(lnk_if.c_dqs_oe_n), .d_dq_oe_n(lnk_if.d_dq_oe_n),
        .d_dqs_oe_n(lnk_if.d_dqs_oe_n), .d_dqsc_oe_n(lnk_if.d_dqsc_oe_n),
        .d_rdqs_oe_n(lnk_if.d_rdqs_oe_n), .dqs(lnk_if.dqs));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // whole link periods of four system cycles, for registered levels to land
    task automatic settle(input int n);
        repeat (4 * n) @(posedge clk_sys_i);
    endtask

    // hold the request until the edge that sees ready; cke travels with it
    task automatic issue(input scpi_pkg::scpi_cmd_type c, input logic [2:0] b, input logic [13:0] a,
                         input logic ck);
        int i;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_cmd_i <= c;
        req_ba_i <= b;
        req_addr_i <= a;
        cke_i <= ck;
        i = 0;
        do begin
            @(negedge clk_sys_i);
            i++;
        end while (req_ready_o !== 1'b1 && i < 40);
        if (req_ready_o !== 1'b1) begin
            failures++;
            summarize();
        end
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
    endtask

    // write then one spare period, so a following read sees the commit
    task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [31:0] d, input logic [3:0] m);
        // a read before this returns at a falling edge; data changes on the rising one
        @(posedge clk_sys_i);
        req_wdata_i <= d;
        req_wmask_i <= m;
        issue(scpi_pkg::SCPI_WR, b, a, 1'b1);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b1);
    endtask

    task automatic rd(input logic [2:0] b, input logic [13:0] a, input logic [31:0] exp);
        int i;
        issue(scpi_pkg::SCPI_RD, b, a, 1'b1);
        i = 0;
        do begin
            @(negedge clk_sys_i);
            i++;
        end while (rsp_valid_o !== 1'b1 && i < 20);
        if (rsp_valid_o !== 1'b1) begin
            failures++;
            summarize();
        end
        cmp_data(rsp_rdata_o, exp);
    endtask

    // cke stays low three link periods after reset, commands from the sixth
    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        cke_i <= 1'b1;
        odt_i <= 1'b1;
        settle(2);
        cmp_reg(16'(odt_on_o), 16'h0000);
        issue(scpi_pkg::SCPI_MRS, 3'h1, 14'h0044, 1'b1);
        issue(scpi_pkg::SCPI_MRS, 3'h2, 14'h0400, 1'b1);
        issue(scpi_pkg::SCPI_MRS, 3'h4, 14'h0400, 1'b1);
        settle(2);
        cmp_reg(emr_o, 16'h0044);
        cmp_reg(16'(odt_on_o), 16'h0001);
        issue(scpi_pkg::SCPI_ACT, 3'h3, 14'h0001, 1'b1);
        issue(scpi_pkg::SCPI_ACT, 3'h5, 14'h0002, 1'b1);
        settle(2);
        cmp_reg(16'(banks_open_o), 16'h0028);
        wr(3'h3, 14'h0005, 32'hA5A5_5A5A, 4'h0);
        rd(3'h3, 14'h0005, 32'hA5A5_5A5A);
        wr(3'h3, 14'h0005, 32'h1234_5678, 4'h6);
        rd(3'h3, 14'h0405, 32'h12A5_5A78);
        settle(2);
        cmp_reg(16'(banks_open_o), 16'h0020);
        rd(3'h3, 14'h0005, 32'h0000_0000);
        issue(scpi_pkg::SCPI_ACT, 3'h3, 14'h0001, 1'b1);
        issue(scpi_pkg::SCPI_PRE, 3'h5, 14'h0000, 1'b1);
        settle(2);
        cmp_reg(16'(banks_open_o), 16'h0008);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b0);
        settle(2);
        cmp_reg(16'(pwr_state_o), 16'(scpi_pkg::PWR_PD_ACT));
        cmp_reg(16'(clk_on_o), 16'h0000);
        issue(scpi_pkg::SCPI_ACT, 3'h1, 14'h0000, 1'b0);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b1);
        settle(2);
        cmp_reg(16'(banks_open_o), 16'h0008);
        cmp_reg(16'(pwr_state_o), 16'(scpi_pkg::PWR_RUN));
        cmp_reg(16'(clk_on_o), 16'h0001);
        issue(scpi_pkg::SCPI_PRE, 3'h0, 14'h0400, 1'b1);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b0);
        settle(2);
        cmp_reg(16'(banks_open_o), 16'h0000);
        cmp_reg(16'(pwr_state_o), 16'(scpi_pkg::PWR_PD_PRE));
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b1);
        issue(scpi_pkg::SCPI_REF, 3'h0, 14'h0000, 1'b0);
        issue(scpi_pkg::SCPI_ACT, 3'h2, 14'h0000, 1'b0);
        settle(1);
        cmp_reg(16'(self_ref_o), 16'h0001);
        cmp_reg(16'(banks_open_o), 16'h0000);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b1);
        settle(1);
        cmp_reg(16'(self_ref_o), 16'h0000);
        issue(scpi_pkg::SCPI_NOP, 3'h0, 14'h0000, 1'b1);
        // single-ended strobe mode, then the same location read again
        issue(scpi_pkg::SCPI_MRS, 3'h1, 14'h0444, 1'b1);
        issue(scpi_pkg::SCPI_ACT, 3'h3, 14'h0001, 1'b1);
        rd(3'h3, 14'h0005, 32'h12A5_5A78);
        summarize();
    end
endmodule // test_sdram_command_pin_interface

// ### logic/scpi_ctl.sv
// scpi_ctl.sv: controller end; makes the link clock and drives commands
// assumes: user side on clk_sys_i; link clock is clk_sys_i divided by four
`timescale 1ns/100ps
`include "scpi_consts.svh"
module scpi_ctl #(
    parameter int DQ_W = 16,
    parameter int AW = 14,
    parameter int MW = 2
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [2:0] req_cmd_i,
    input wire logic [2:0] req_ba_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [2*DQ_W-1:0] req_wdata_i,
    input wire logic [2*MW-1:0] req_wmask_i,
    input wire logic cke_i,
    input wire logic odt_i,
    output logic rsp_valid_o,
    output logic [2*DQ_W-1:0] rsp_rdata_o,
    scpi_if.ctl lnk
);
    logic [1:0] cnt_q;
    logic [2:0] cmd_q;
    logic [3:0] pins_q;
    logic [3:0] code_d;
    logic [2:0] ba_q;
    logic [AW-1:0] addr_q;
    logic cke_q;
    logic odt_q;
    logic [2*DQ_W-1:0] wbuf_q;
    logic [2*MW-1:0] wmsk_q;
    logic [DQ_W-1:0] dq_q;
    logic [MW-1:0] dm_q;
    logic oe_n_q;
    logic dqs_q;
    logic wdat_q;
    logic rdat_q;
    logic take;

    // one request per link period, none while a burst is on the bus
    assign req_ready_o = (cnt_q == `SCPI_PH_HI1) && !wdat_q && !rdat_q;
    assign take = req_valid_i && req_ready_o;

    // pin code of the user command; no command means deselect
    always_comb begin
        case (req_cmd_i)
            scpi_pkg::SCPI_MRS: code_d = `SCPI_CMD_MRS;
            scpi_pkg::SCPI_REF: code_d = `SCPI_CMD_REF;
            scpi_pkg::SCPI_PRE: code_d = `SCPI_CMD_PRE;
            scpi_pkg::SCPI_ACT: code_d = `SCPI_CMD_ACT;
            scpi_pkg::SCPI_WR: code_d = `SCPI_CMD_WR;
            scpi_pkg::SCPI_RD: code_d = `SCPI_CMD_RD;
            default: code_d = `SCPI_CMD_DES;
        endcase
    end

    // clock divider; ck stands low while in reset
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= `SCPI_PH_LO0;
        end else begin
            cnt_q <= cnt_q + `SCPI_PH_STEP;
        end
    end

    // command launch on the ck falling edge, centred on the next rise
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pins_q <= `SCPI_CMD_DES;
            cmd_q <= scpi_pkg::SCPI_NOP;
            ba_q <= '0;
            addr_q <= '0;
            cke_q <= 1'b0;
            odt_q <= 1'b0;
            wbuf_q <= '0;
            wmsk_q <= '0;
        end else if (cnt_q == `SCPI_PH_HI1) begin
            pins_q <= take ? code_d : `SCPI_CMD_DES;
            cmd_q <= take ? req_cmd_i : scpi_pkg::SCPI_NOP;
            ba_q <= req_ba_i;
            addr_q <= req_addr_i;
            cke_q <= cke_i;
            odt_q <= odt_i;
            if (take) begin
                wbuf_q <= req_wdata_i;
                wmsk_q <= req_wmask_i;
            end
        end
    end

    // write beats: beat 0 from ck rise+1, beat 1 half a period later
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdat_q <= 1'b0;
            rdat_q <= 1'b0;
            oe_n_q <= 1'b1;
            dq_q <= '0;
            dm_q <= '0;
        end else if (cnt_q == `SCPI_PH_HI0) begin
            wdat_q <= cmd_q == scpi_pkg::SCPI_WR;
            rdat_q <= cmd_q == scpi_pkg::SCPI_RD;
            oe_n_q <= cmd_q != scpi_pkg::SCPI_WR;
            dq_q <= wbuf_q[DQ_W-1:0];
            dm_q <= wmsk_q[MW-1:0];
        end else if (cnt_q == `SCPI_PH_LO0 && wdat_q) begin
            dq_q <= wbuf_q[2*DQ_W-1:DQ_W];
            dm_q <= wmsk_q[2*MW-1:MW];
        end
    end

    // write strobe: edges in the middle of each beat, low preamble first
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dqs_q <= 1'b0;
        end else if (cnt_q == `SCPI_PH_HI1 && wdat_q) begin
            dqs_q <= 1'b1;
        end else if (cnt_q == `SCPI_PH_LO1) begin
            dqs_q <= 1'b0;
        end
    end

    // read capture late in each half period, where the device data is settled
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end else begin
            rsp_valid_o <= (cnt_q == `SCPI_PH_LO1) && rdat_q;
            if (cnt_q == `SCPI_PH_HI1 && rdat_q) begin
                rsp_rdata_o[DQ_W-1:0] <= lnk.dq;
            end
            if (cnt_q == `SCPI_PH_LO1 && rdat_q) begin
                rsp_rdata_o[2*DQ_W-1:DQ_W] <= lnk.dq;
            end
        end
    end

    // pins
    assign lnk.ck_t = cnt_q[1];
    assign lnk.ck_c = ~cnt_q[1];
    assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = pins_q;
    assign lnk.ba = ba_q;
    assign lnk.addr = addr_q;
    assign lnk.cke = cke_q;
    assign lnk.odt = odt_q;
    assign lnk.dm = dm_q;
    assign lnk.c_dq_o = dq_q;
    assign lnk.c_dq_oe_n = oe_n_q;
    assign lnk.c_dqs_o = dqs_q;
    assign lnk.c_dqs_oe_n = oe_n_q;
endmodule // scpi_ctl

// ### logic/scpi_dev.sv
// scpi_dev.sv: memory-device end of the ddr2 command, address and data pins
// assumes: runs on the link clock ck_t; the pins are launched centred on
// its rising edge by the controller; sys_rst_i is async from the system side
`timescale 1ns/100ps
`include "scpi_consts.svh"
module scpi_dev #(
    parameter int DQ_W = 16,
    parameter int AW = 14,
    parameter int MW = 2,
    parameter int COL_W = 4,
    parameter int ROW_B = 2
) (
    scpi_if.dev lnk,
    input wire logic sys_rst_i,
    output logic clk_on_o,
    output logic [2:0] pwr_state_o,
    output logic self_ref_o,
    output logic odt_on_o,
    output logic [7:0] banks_open_o,
    output logic [15:0] emr_o
);
    localparam int NB = `SCPI_BANKS;
    localparam int LW = DQ_W / MW;
    localparam int IW = 3 + ROW_B + COL_W;
    localparam int DEPTH = 1 << IW;

    logic rst;
    logic sr_wake;
    logic cke_q;
    logic odt_q;
    logic sr_q;
    scpi_pkg::scpi_pwr_type pwr_q;
    scpi_pkg::scpi_pwr_type pwr_d;
    logic [3:0] code;
    logic live;
    logic exe;
    logic sr_entry;
    logic [NB-1:0] open_q;
    logic [AW-1:0] row_q [NB];
    logic [15:0] mr_q [4];
    logic [IW-1:0] idx;
    logic [IW-1:0] widx1_q;
    logic [IW-1:0] widx2_q;
    logic wp1_q;
    logic wp2_q;
    logic rd_act_q;
    logic [2*DQ_W-1:0] mem [DEPTH];
    logic [2*DQ_W-1:0] rdw_q;
    logic [2*DQ_W-1:0] merged;
    logic [DQ_W-1:0] wb0_q;
    logic [DQ_W-1:0] wb1_q;
    logic [MW-1:0] wm0_q;
    logic [MW-1:0] wm1_q;
    logic rtt_en;
    logic rdqs_en;

    // reset released on the link clock, which only runs once the host is up
    scpi_rst_sync u_rst (
        .clk_i(lnk.ck_t),
        .rst_i(sys_rst_i),
        .rst_o(rst)
    );

    // command decode; any code with cs_n high matches no command
    assign code = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n};
    assign live = (pwr_q == scpi_pkg::PWR_RUN) && !sr_q && cke_q;
    assign exe = live && lnk.cke;
    assign sr_entry = live && !lnk.cke && (code == `SCPI_CMD_REF);
    assign idx = {lnk.ba, row_q[lnk.ba][ROW_B-1:0], lnk.addr[COL_W-1:0]};

    // cke and odt registered on the rising true clock
    always_ff @(posedge lnk.ck_t or posedge rst) begin
        if (rst) begin
            cke_q <= 1'b0;
            odt_q <= 1'b0;
        end else begin
            cke_q <= lnk.cke;
            odt_q <= lnk.odt && !sr_q;
        end
    end

    // self refresh: cke high leaves it with no clock edge needed
    // the clear path is combinational from the pin, so keep cke glitch free
    assign sr_wake = rst | lnk.cke;
    always_ff @(posedge lnk.ck_t or posedge sr_wake) begin
        if (sr_wake) begin
            sr_q <= 1'b0;
        end else if (sr_entry) begin
            sr_q <= 1'b1;
        end
    end

    // power-down next state
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            scpi_pkg::PWR_RUN: begin
                if (live && !lnk.cke && !sr_entry) begin
                    pwr_d = (|open_q) ? scpi_pkg::PWR_PD_ACT : scpi_pkg::PWR_PD_PRE;
                end
            end
            scpi_pkg::PWR_PD_PRE, scpi_pkg::PWR_PD_ACT: begin
                if (lnk.cke) begin
                    pwr_d = scpi_pkg::PWR_RUN;
                end
            end
            default: begin
                pwr_d = scpi_pkg::PWR_RUN;
            end
        endcase
    end

    // power state register
    always_ff @(posedge lnk.ck_t or posedge rst) begin
        if (rst) begin
            pwr_q <= scpi_pkg::PWR_RUN;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // bank open flags and mode registers
    always_ff @(posedge lnk.ck_t or posedge rst) begin
        if (rst) begin
            open_q <= '0;
            for (int i = 0; i < 4; i++) begin
                mr_q[i] <= `SCPI_MR_RST;
            end
        end else if (exe) begin
            case (code)
                `SCPI_CMD_ACT: begin
                    open_q[lnk.ba] <= 1'b1;
                end
                `SCPI_CMD_PRE: begin
                    if (lnk.addr[`SCPI_A10]) begin
                        open_q <= '0;
                    end else begin
                        open_q[lnk.ba] <= 1'b0;
                    end
                end
                `SCPI_CMD_WR, `SCPI_CMD_RD: begin
                    if (lnk.addr[`SCPI_A10]) begin
                        open_q[lnk.ba] <= 1'b0;
                    end
                end
                `SCPI_CMD_MRS: begin
                    if (!lnk.ba[2]) begin
                        mr_q[lnk.ba[1:0]] <= 16'(lnk.addr);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // open row per bank, no reset needed: only read behind an open flag
    always_ff @(posedge lnk.ck_t) begin
        if (exe && code == `SCPI_CMD_ACT) begin
            row_q[lnk.ba] <= lnk.addr;
        end
    end

    // write commit waits two periods so the last strobe edge has landed
    always_ff @(posedge lnk.ck_t or posedge rst) begin
        if (rst) begin
            wp1_q <= 1'b0;
            wp2_q <= 1'b0;
            widx1_q <= '0;
            widx2_q <= '0;
            rd_act_q <= 1'b0;
        end else begin
            wp1_q <= exe && code == `SCPI_CMD_WR && open_q[lnk.ba];
            widx1_q <= idx;
            wp2_q <= wp1_q;
            widx2_q <= widx1_q;
            rd_act_q <= exe && code == `SCPI_CMD_RD && open_q[lnk.ba];
        end
    end

    // array write and read; a read in the commit period sees the old word
    always_ff @(posedge lnk.ck_t) begin
        if (wp2_q) begin
            mem[widx2_q] <= merged;
        end
        if (exe && code == `SCPI_CMD_RD) begin
            rdw_q <= mem[idx];
        end
    end

    // beat capture on each strobe edge, source synchronous to the controller
    always_ff @(posedge lnk.dqs) begin
        wb0_q <= lnk.dq;
        wm0_q <= lnk.dm;
    end

    always_ff @(negedge lnk.dqs) begin
        wb1_q <= lnk.dq;
        wm1_q <= lnk.dm;
    end

    // per-lane merge: a masked lane keeps the stored bits
    for (genvar g = 0; g < MW; g++) begin : g_lane
        assign merged[g*LW +: LW] = wm0_q[g] ? mem[widx2_q][g*LW +: LW] : wb0_q[g*LW +: LW];
        assign merged[DQ_W+g*LW +: LW] = wm1_q[g] ? mem[widx2_q][DQ_W+g*LW +: LW]
                                                  : wb1_q[g*LW +: LW];
    end

    // mode decode from the extended register
    assign rtt_en = mr_q[`SCPI_MR_EMR][`SCPI_RTT_LO] | mr_q[`SCPI_MR_EMR][`SCPI_RTT_HI];
    assign rdqs_en = (DQ_W == 8) && mr_q[`SCPI_MR_EMR][`SCPI_E11];

    // read drive: beat 0 while ck high, beat 1 while low; cke low disables
    assign lnk.d_dq_o = lnk.ck_t ? rdw_q[DQ_W-1:0] : rdw_q[2*DQ_W-1:DQ_W];
    assign lnk.d_dq_oe_n = !(rd_act_q && cke_q);
    assign lnk.d_dqs_o = lnk.ck_t;
    assign lnk.d_dqs_oe_n = !(rd_act_q && cke_q);
    assign lnk.d_dqsc_oe_n = !(rd_act_q && cke_q && !mr_q[`SCPI_MR_EMR][`SCPI_E10]);
    assign lnk.d_rdqs_o = lnk.ck_t;
    assign lnk.d_rdqs_oe_n = !(rd_act_q && cke_q && rdqs_en);

    // user-side status, all on the link clock
    assign clk_on_o = cke_q && !sr_q;
    assign pwr_state_o = pwr_q;
    assign self_ref_o = sr_q;
    assign odt_on_o = odt_q && rtt_en;
    assign banks_open_o = open_q;
    assign emr_o = mr_q[`SCPI_MR_EMR];
endmodule // scpi_dev

// ### logic/scpi_rst_sync.sv
// scpi_rst_sync.sv: reset synchroniser, async assert and clocked release
// assumes: clk_i may stand still; release waits for two of its edges
`timescale 1ns/100ps
module scpi_rst_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic rst_o
);
    logic meta_q;
    logic hold_q;

    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            hold_q <= 1'b1;
        end else begin
            meta_q <= 1'b0;
            hold_q <= meta_q;
        end
    end

    assign rst_o = hold_q;
endmodule // scpi_rst_sync

// ### pkg/scpi_consts.svh
// scpi_consts.svh: pin codes, bit positions, reset values and link phases
// assumes: included by bare name wherever the link is decoded or driven
`ifndef SCPI_CONSTS_SVH
`define SCPI_CONSTS_SVH

// command pin codes {cs_n, ras_n, cas_n, we_n}
`define SCPI_CMD_MRS 4'h0
`define SCPI_CMD_REF 4'h1
`define SCPI_CMD_PRE 4'h2
`define SCPI_CMD_ACT 4'h3
`define SCPI_CMD_WR 4'h4
`define SCPI_CMD_RD 4'h5
`define SCPI_CMD_DES 4'hF

// address and mode bit positions
`define SCPI_A10 10
`define SCPI_RTT_LO 2
`define SCPI_RTT_HI 6
`define SCPI_E10 10
`define SCPI_E11 11
`define SCPI_MR_EMR 1
`define SCPI_BANKS 8
`define SCPI_MR_RST 16'h0000

// divider phases of the link clock (clk_sys cycles, ck high in HI0/HI1)
`define SCPI_PH_LO0 2'h0
`define SCPI_PH_LO1 2'h1
`define SCPI_PH_HI0 2'h2
`define SCPI_PH_HI1 2'h3
`define SCPI_PH_STEP 2'h1

`endif

// ### pkg/scpi_if.sv
// scpi_if.sv: ddr2 ball-level link between controller and device
// assumes: the bench instantiates it and hands each end its modport
`timescale 1ns/100ps
interface scpi_if #(
    parameter int DQ_W = 16,
    parameter int AW = 14,
    parameter int MW = 2
);
    logic ck_t;
    logic ck_c;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [AW-1:0] addr;
    logic [MW-1:0] dm;
    logic [DQ_W-1:0] c_dq_o;
    logic c_dq_oe_n;
    logic c_dqs_o;
    logic c_dqs_oe_n;
    logic [DQ_W-1:0] d_dq_o;
    logic d_dq_oe_n;
    logic d_dqs_o;
    logic d_dqs_oe_n;
    logic d_dqsc_oe_n;
    logic d_rdqs_o;
    logic d_rdqs_oe_n;
    logic [DQ_W-1:0] dq;
    logic dqs;
    logic dqs_c;
    logic rdqs;

    // wire resolution; an undriven bus reads low
    assign dq = !c_dq_oe_n ? c_dq_o : (!d_dq_oe_n ? d_dq_o : '0);
    assign dqs = !c_dqs_oe_n ? c_dqs_o : (!d_dqs_oe_n ? d_dqs_o : 1'b0);
    assign dqs_c = ~dqs;
    assign rdqs = !d_rdqs_oe_n ? d_rdqs_o : 1'b0;

    modport ctl (
        output ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
        output c_dq_o, c_dq_oe_n, c_dqs_o, c_dqs_oe_n,
        input dq
    );
    modport dev (
        input ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
        input dq, dqs,
        output d_dq_o, d_dq_oe_n, d_dqs_o, d_dqs_oe_n, d_dqsc_oe_n,
        output d_rdqs_o, d_rdqs_oe_n
    );
endinterface

// ### pkg/scpi_pkg.sv
// scpi_pkg.sv: user command and power-state types of the pin interface
// assumes: nothing beyond a SystemVerilog compiler
package scpi_pkg;
    typedef enum logic [2:0] {
        SCPI_NOP = 3'h0,
        SCPI_MRS = 3'h1,
        SCPI_REF = 3'h2,
        SCPI_PRE = 3'h3,
        SCPI_ACT = 3'h4,
        SCPI_WR = 3'h5,
        SCPI_RD = 3'h6
    } scpi_cmd_type;

    // one-hot power states of the device end
    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_PD_PRE = 3'h2,
        PWR_PD_ACT = 3'h4
    } scpi_pwr_type;
endpackage
